// File: include/record_dsp_regs_consts.svh
/*
   Register indices, field widths and reset values of the record-path processor
   and clock-output multiplexer register bank.
   Assumes the including file sits on a 32-bit APB bus with one register per aligned word.
*/
`ifndef RECORD_DSP_REGS_CONSTS_SVH
`define RECORD_DSP_REGS_CONSTS_SVH

// -----------------------------------------------------------------------------
// Register indices; the byte address is four times the index.
// -----------------------------------------------------------------------------
`define IDX_COUNT_UPPER     10'h015
`define IDX_COUNT_LOWER     10'h016
`define IDX_DECIMATION      10'h017
`define IDX_RESERVED_SLOT   10'h018
`define IDX_CLKOUT_SELECT   10'h019

// -----------------------------------------------------------------------------
// Field widths.
// -----------------------------------------------------------------------------
`define COUNT_UPPER_W       7
`define COUNT_LOWER_W       8
`define DECIMATION_W        4
`define CLKOUT_SELECT_W     3

// -----------------------------------------------------------------------------
// Reset values of the writable fields and of the read-only reserved slot.
// -----------------------------------------------------------------------------
`define RST_COUNT_UPPER     7'h01
`define RST_COUNT_LOWER     8'h00
`define RST_DECIMATION      4'h4
`define RST_CLKOUT_SELECT   3'h0
`define RST_RESERVED_SLOT   8'h00

// -----------------------------------------------------------------------------
// Decoded values for an all-zero code.
// -----------------------------------------------------------------------------
`define COUNT_ZERO_VALUE    16'h8000
`define DECIMATION_ZERO_VAL 5'h10

`endif

// File: include/record_dsp_regs_pkg.sv
/*
   Types shared by the record-path processor register bank.
   Assumes nothing of its surroundings.
*/
package record_dsp_regs_pkg;

   typedef logic [14:0] instr_code_t;
   typedef logic [15:0] instr_value_t;
   typedef logic [4:0]  factor_value_t;

   typedef enum logic [2:0] {
      src_master_clock           = 3'h0,
      src_bit_clock              = 3'h1,
      src_serial_data_in         = 3'h2,
      src_pll_output             = 3'h3,
      src_playback_filter_clock  = 3'h4,
      src_playback_modulator_clock = 3'h5,
      src_record_filter_clock    = 3'h6,
      src_record_modulator_clock = 3'h7
   } clock_source_t;

endpackage

// File: logic/record_dsp_cycle_and_clock_mux_regs.sv
/*
   APB register bank for the record-path processor instruction count, its decimation
   factor, one reserved slot and the clock-output divider source selector.
   Assumes an APB master on pclk, and a record_processor_select level from logic on pclk.
*/
// The APB interface to the registers was chosen for this implementation.


`include "record_dsp_regs_consts.svh"

module record_dsp_cycle_and_clock_mux_regs (
   input  wire logic                                        pclk,
   input  wire logic                                        presetn,
   input  wire logic                                        psel,
   input  wire logic                                        penable,
   input  wire logic                                        pwrite,
   input  wire logic [11:0]                                 paddr,
   input  wire logic [31:0]                                 pwdata,
   output logic      [31:0]                                 prdata,
   output logic                                             pready,
   output logic                                             pslverr,
   input  wire logic                                        record_processor_select,
   output record_dsp_regs_pkg::instr_value_t                record_dsp_instruction_count,
   output record_dsp_regs_pkg::factor_value_t               record_dsp_decimation_factor,
   output record_dsp_regs_pkg::clock_source_t               clock_output_divider_input
);

   // --------------------------------------------------------------------------
   // Decode helpers
   // --------------------------------------------------------------------------
   function automatic logic addr_is(input logic [11:0] addr, input logic [9:0] idx);
      addr_is = (addr == {idx, 2'b00});
   endfunction

   function automatic record_dsp_regs_pkg::instr_value_t count_value(
      input record_dsp_regs_pkg::instr_code_t code);
      if (code == 15'h0000) begin
         count_value = `COUNT_ZERO_VALUE;
      end else begin
         count_value = {1'b0, code};
      end
   endfunction

   function automatic record_dsp_regs_pkg::factor_value_t factor_value(input logic [3:0] code);
      if (code == 4'h0) begin
         factor_value = `DECIMATION_ZERO_VAL;
      end else begin
         factor_value = {1'b0, code};
      end
   endfunction

   // --------------------------------------------------------------------------
   // Bus handshake
   // --------------------------------------------------------------------------
   logic                          access_phase;
   logic                          transfer_done;
   logic                          addr_hit;
   logic                          wr_upper;
   logic                          wr_lower;
   logic                          wr_decimation;
   logic                          wr_clksel;
   logic [31:0]                   next_prdata;

   logic [`COUNT_UPPER_W-1:0]     count_upper;
   logic [`COUNT_LOWER_W-1:0]     count_lower;
   logic [`COUNT_UPPER_W-1:0]     staged_upper;
   logic                          upper_pending;
   logic [`DECIMATION_W-1:0]      decimation;
   logic [`CLKOUT_SELECT_W-1:0]   clkout_select;

   assign access_phase  = psel & penable;
   assign transfer_done = access_phase & pready;
   assign addr_hit      = addr_is(paddr, `IDX_COUNT_UPPER) | addr_is(paddr, `IDX_COUNT_LOWER) |
                          addr_is(paddr, `IDX_DECIMATION) | addr_is(paddr, `IDX_RESERVED_SLOT) |
                          addr_is(paddr, `IDX_CLKOUT_SELECT);
   assign wr_upper      = transfer_done & pwrite & addr_is(paddr, `IDX_COUNT_UPPER);
   assign wr_lower      = transfer_done & pwrite & addr_is(paddr, `IDX_COUNT_LOWER);
   assign wr_decimation = transfer_done & pwrite & addr_is(paddr, `IDX_DECIMATION);
   assign wr_clksel     = transfer_done & pwrite & addr_is(paddr, `IDX_CLKOUT_SELECT);

   // One wait state: pready rises in the second access cycle, so every answer is registered.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= access_phase & ~pready;
      end
   end

   // --------------------------------------------------------------------------
   // Read data
   // --------------------------------------------------------------------------
   always_comb begin
      next_prdata = 32'h0000_0000;
      if (addr_is(paddr, `IDX_COUNT_UPPER)) begin
         next_prdata = {25'h000_0000, count_upper};
      end else if (addr_is(paddr, `IDX_COUNT_LOWER)) begin
         next_prdata = {24'h00_0000, count_lower};
      end else if (addr_is(paddr, `IDX_DECIMATION)) begin
         next_prdata = {28'h000_0000, decimation};
      end else if (addr_is(paddr, `IDX_RESERVED_SLOT)) begin
         next_prdata = {24'h00_0000, `RST_RESERVED_SLOT};
      end else if (addr_is(paddr, `IDX_CLKOUT_SELECT)) begin
         next_prdata = {29'h000_0000, clkout_select};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (access_phase & ~pready) begin
         // An unmapped access still completes, so a careless master cannot hang the bus.
         prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
         pslverr <= ~addr_hit;
      end else begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
   end

   // --------------------------------------------------------------------------
   // Instruction count with deferred upper byte
   // --------------------------------------------------------------------------
   // A staged upper byte is dropped by any other completed command, so a stray access
   // between the two halves cannot leave a half-programmed count waiting.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         staged_upper  <= `RST_COUNT_UPPER;
         upper_pending <= 1'b0;
      end else if (wr_upper) begin
         staged_upper  <= pwdata[`COUNT_UPPER_W-1:0];
         upper_pending <= 1'b1;
      end else if (transfer_done) begin
         upper_pending <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_upper <= `RST_COUNT_UPPER;
         count_lower <= `RST_COUNT_LOWER;
      end else if (wr_lower) begin
         count_lower <= pwdata[`COUNT_LOWER_W-1:0];
         if (upper_pending) begin
            count_upper <= staged_upper;
         end
      end
   end

   // --------------------------------------------------------------------------
   // Decimation and clock-output source
   // --------------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         decimation <= `RST_DECIMATION;
      end else if (wr_decimation) begin
         decimation <= pwdata[`DECIMATION_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clkout_select <= `RST_CLKOUT_SELECT;
      end else if (wr_clksel) begin
         clkout_select <= pwdata[`CLKOUT_SELECT_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_output_divider_input <= record_dsp_regs_pkg::src_master_clock;
      end else begin
         clock_output_divider_input <= record_dsp_regs_pkg::clock_source_t'(clkout_select);
      end
   end

   // --------------------------------------------------------------------------
   // Decoded settings toward the record path
   // --------------------------------------------------------------------------
   // Deselected, the count and factor outputs sit at zero, which no legal decoded value can equal.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         record_dsp_instruction_count <= 16'h0000;
         record_dsp_decimation_factor <= 5'h00;
      end else if (record_processor_select) begin
         record_dsp_instruction_count <= count_value({count_upper, count_lower});
         record_dsp_decimation_factor <= factor_value(decimation);
      end else begin
         record_dsp_instruction_count <= 16'h0000;
         record_dsp_decimation_factor <= 5'h00;
      end
   end

   // --------------------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic after_reset_seen;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         after_reset_seen <= 1'b0;
      end else begin
         after_reset_seen <= 1'b1;
      end
   end

   a_reset_count_value: assert property (
      !after_reset_seen |-> ({count_upper, count_lower} == 15'h0100))
      else $error("Instruction count is not 256 after reset.");

   a_upper_read_layout: assert property (
      pready && psel && !pwrite && addr_is(paddr, `IDX_COUNT_UPPER)
      |-> (prdata == {25'h000_0000, count_upper}))
      else $error("Upper count read does not show bits 14 to 8 in the low seven bits.");

   a_zero_count_max: assert property (
      record_processor_select && ({count_upper, count_lower} == 15'h0000)
      |=> (record_dsp_instruction_count == 16'h8000))
      else $error("All-zero count code does not decode to 32768.");

   a_nonzero_count_value: assert property (
      record_processor_select && ({count_upper, count_lower} != 15'h0000)
      |=> (record_dsp_instruction_count == {1'b0, $past({count_upper, count_lower})}))
      else $error("Nonzero count code does not decode to its own value.");

   a_upper_deferred: assert property (
      wr_upper |=> (count_upper == $past(count_upper)) ##1 (upper_pending || count_upper == $past(count_upper, 2)))
      else $error("Upper count byte took effect before the lower byte was written.");

   a_upper_commit: assert property (
      wr_lower && upper_pending |=> (count_upper == $past(staged_upper)) && !upper_pending)
      else $error("Staged upper count byte was not committed by the lower write.");

   a_pending_cancel: assert property (
      transfer_done && !wr_upper && !wr_lower |=> !upper_pending)
      else $error("Staged upper byte survived an intervening command.");

   a_factor_decode: assert property (
      record_processor_select |=>
      (record_dsp_decimation_factor == (($past(decimation) == 4'h0) ? 5'h10 : {1'b0, $past(decimation)})))
      else $error("Decimation factor decode is wrong.");

   a_deselect_quiet: assert property (
      !record_processor_select |=> (record_dsp_instruction_count == 16'h0000)
      && (record_dsp_decimation_factor == 5'h00))
      else $error("Record path settings leak while the processor is deselected.");

   a_reserved_read_zero: assert property (
      pready && psel && !pwrite && (addr_is(paddr, `IDX_DECIMATION) || addr_is(paddr, `IDX_RESERVED_SLOT)
      || addr_is(paddr, `IDX_CLKOUT_SELECT)) |-> (prdata[31:4] == 28'h000_0000)
      && (!addr_is(paddr, `IDX_RESERVED_SLOT) || prdata == 32'h0000_0000))
      else $error("Reserved bits do not read as their reset value.");

   a_clock_select_write: assert property (
      wr_clksel |=> ##1 (clock_output_divider_input == $past(pwdata[2:0], 2)))
      else $error("Clock-output divider source did not follow the write.");

   a_answer_timing: assert property (
      access_phase && !pready |=> pready ##1 !pready)
      else $error("Bus answer did not come exactly one cycle into the access phase.");

   // Data and error only show in the answer cycle, so a master that samples late reads zero.
   a_idle_bus_quiet: assert property (
      !pready |-> (prdata == 32'h0000_0000) && !pslverr)
      else $error("Read data or error shows outside the answer cycle.");

   a_unmapped_refused: assert property (
      access_phase && !pready && !addr_hit |=> pready && pslverr && (prdata == 32'h0000_0000))
      else $error("Unmapped access was not answered with an error and zero data.");

   a_lower_write_lands: assert property (
      wr_lower |=> (count_lower == $past(pwdata[7:0])))
      else $error("Lower count byte did not take the written value.");

   a_pending_set: assert property (
      wr_upper |=> upper_pending && (staged_upper == $past(pwdata[6:0])))
      else $error("Upper count byte was not staged by its write.");

   a_lower_only_commit: assert property (
      wr_lower && !upper_pending |=> (count_upper == $past(count_upper)))
      else $error("Lower write alone changed the upper count byte.");

   a_source_follows: assert property (
      clock_output_divider_input == $past(clkout_select))
      else $error("Clock-output divider source does not follow its register.");

   c_split_count_write: cover property (wr_upper ##[1:8] wr_lower);
   c_zero_count_used: cover property (record_processor_select && {count_upper, count_lower} == 15'h0000);
   c_unmapped_access: cover property (pready && pslverr);
   c_last_clock_source: cover property (wr_clksel && pwdata[2:0] == 3'h7);
   c_pending_dropped: cover property (upper_pending && transfer_done && !wr_upper && !wr_lower);

endmodule

// File: sim/tb.sv
/*
   Self-checking bench for the record-path processor register bank and clock-output selector.
   Assumes the register bank answers APB with one wait state and takes its reset from presetn.
*/
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   // -----------------------------------------------------------------------------
   // Signals.
   // -----------------------------------------------------------------------------
   localparam logic [11:0] a_up  = 12'h054;
   localparam logic [11:0] a_lo  = 12'h058;
   localparam logic [11:0] a_dec = 12'h05C;
   localparam logic [11:0] a_rsv = 12'h060;
   localparam logic [11:0] a_sel = 12'h064;
   logic                                  pclk;
   logic                                  presetn;
   logic                                  psel;
   logic                                  penable;
   logic                                  pwrite;
   logic [11:0]                           paddr;
   logic [31:0]                           pwdata;
   logic [31:0]                           prdata;
   logic                                  pready;
   logic                                  pslverr;
   logic                                  sel_rec;
   record_dsp_regs_pkg::instr_value_t     cnt;
   record_dsp_regs_pkg::factor_value_t    fac;
   record_dsp_regs_pkg::clock_source_t    src;
   logic [31:0]                           rd;
   logic                                  err;
   logic [6:0]                            up;
   logic [7:0]                            lo;
   int                                    bad_count;
   int                                    checks_done;
   int                                    cycles;

   record_dsp_cycle_and_clock_mux_regs uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .record_processor_select(sel_rec), .record_dsp_instruction_count(cnt),
      .record_dsp_decimation_factor(fac), .clock_output_divider_input(src));

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   // -----------------------------------------------------------------------------
   // Helpers.
   // -----------------------------------------------------------------------------
   function automatic logic [31:0] exp_count(input logic [14:0] code);
      return (code == 15'h0000) ? 32'h0000_8000 : {17'h0_0000, code};
   endfunction

   function automatic logic [31:0] exp_factor(input logic [3:0] code);
      return (code == 4'h0) ? 32'h0000_0010 : {28'h000_0000, code};
   endfunction

   task automatic finish_test();
      $display("Checks made %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // The request is held until pready is sampled high; only then is it released.
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] addr, input logic [31:0] wd);
      apb(1'b1, addr, wd);
      check("write pslverr", {31'h0, err}, 32'h0);
   endtask

   task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp, input string what);
      apb(1'b0, addr, 32'h0);
      check(what, rd, exp);
      check("read pslverr", {31'h0, err}, 32'h0);
   endtask

   // Decoded outputs trail the register by one cycle; three edges leave margin.
   task automatic settle();
      repeat (3) @(posedge pclk);
      #1;
   endtask

   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         finish_test();
      end
   end

   // -----------------------------------------------------------------------------
   // Main sequence.
   // -----------------------------------------------------------------------------
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0; sel_rec = 1'b1;
      bad_count = 0; checks_done = 0; cycles = 0;
      void'($urandom(52));
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(a_up, 32'h0000_0001, "upper reset");
      rd_chk(a_lo, 32'h0000_0000, "lower reset");
      rd_chk(a_dec, 32'h0000_0004, "decimation reset");
      rd_chk(a_rsv, 32'h0000_0000, "reserved reset");
      rd_chk(a_sel, 32'h0000_0000, "selector reset");
      settle();
      check("count reset", cnt, 32'h0000_0100);
      check("factor reset", fac, 32'h0000_0004);
      check("source reset", src, 32'h0000_0000);
      // Zero and all-ones codes first, then random pairs kept to multiples of the factor 4.
      for (int i = 0; i < 10; i++) begin
         up = (i == 0) ? 7'h00 : (i == 1) ? 7'h7F : 7'($urandom);
         lo = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom) & 8'hFC;
         wr(a_up, {25'h0, up});
         wr(a_lo, {24'h0, lo});
         rd_chk(a_up, {25'h0, up}, "upper after pair");
         rd_chk(a_lo, {24'h0, lo}, "lower after pair");
         settle();
         check("decoded count", cnt, exp_count({up, lo}));
      end
      // A staged upper byte is lost when a read or another write comes between.
      wr(a_up, {25'h0, ~up});
      rd_chk(a_up, {25'h0, up}, "upper staged not visible");
      wr(a_lo, 32'h0000_0033);
      rd_chk(a_up, {25'h0, up}, "upper after broken pair");
      wr(a_up, {25'h0, ~up});
      wr(a_dec, 32'h0000_0003);
      wr(a_lo, 32'h0000_0044);
      rd_chk(a_up, {25'h0, up}, "upper after other write");
      settle();
      check("count after broken pair", cnt, exp_count({up, 8'h44}));
      for (int c = 0; c < 16; c++) begin
         wr(a_dec, 32'(c));
         settle();
         check("decoded factor", fac, exp_factor(4'(c)));
      end
      for (int c = 0; c < 8; c++) begin
         wr(a_sel, 32'(c));
         rd_chk(a_sel, 32'(c), "selector readback");
         settle();
         check("divider source", src, 32'(c));
      end
      // Ones written into reserved bits must not show.
      wr(a_up, 32'hFFFF_FFFF);
      wr(a_lo, 32'hFFFF_FFFF);
      rd_chk(a_up, 32'h0000_007F, "upper reserved bit");
      wr(a_dec, 32'hFFFF_FFF5);
      rd_chk(a_dec, 32'h0000_0005, "decimation reserved bits");
      wr(a_rsv, 32'hFFFF_FFFF);
      rd_chk(a_rsv, 32'h0000_0000, "reserved register");
      wr(a_sel, 32'hFFFF_FFFA);
      rd_chk(a_sel, 32'h0000_0002, "selector reserved bits");
      apb(1'b0, 12'h068, 32'h0);
      check("unmapped pslverr", {31'h0, err}, 32'h1);
      check("unmapped data", rd, 32'h0);
      // Deselecting the record processor silences count and factor only.
      @(posedge pclk);
      sel_rec <= 1'b0;
      settle();
      check("count deselected", cnt, 32'h0);
      check("factor deselected", fac, 32'h0);
      check("source deselected", src, 32'h0000_0002);
      @(posedge pclk);
      sel_rec <= 1'b1;
      settle();
      check("count reselected", cnt, 32'h0000_7FFF);
      check("factor reselected", fac, 32'h0000_0005);
      // A mid-run reset must drop a staged upper byte and restore every default.
      wr(a_up, 32'h0000_0055);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      wr(a_lo, 32'h0000_0000);
      rd_chk(a_up, 32'h0000_0001, "upper after mid-run reset");
      rd_chk(a_dec, 32'h0000_0004, "decimation after mid-run reset");
      rd_chk(a_sel, 32'h0000_0000, "selector after mid-run reset");
      settle();
      check("count after mid-run reset", cnt, 32'h0000_0100);
      check("factor after mid-run reset", fac, 32'h0000_0004);
      check("source after mid-run reset", src, 32'h0000_0000);
      finish_test();
   end
endmodule
